// ==== rtl/jk_cell_params.svh ====
// Reset values and idle levels for the JK storage elements.
`ifndef JK_CELL_PARAMS_SVH
`define JK_CELL_PARAMS_SVH

`define Q_RESET         1'b0
`define QB_RESET        1'b1
`define PINS_A_IDLE     4'h1
`define PINS_B_IDLE     5'h00
`define SYNC_STAGES     2

`endif

// ==== rtl/jk_cell_pkg.sv ====
// Types for the JK storage elements: synchronised pin groups and the module state.
package jk_cell_pkg;

	typedef struct packed {
		logic tick;
		logic j;
		logic k;
		logic clr_n;
	} pins_a_t;

	typedef struct packed {
		logic tick;
		logic j;
		logic k;
		logic set;
		logic clr;
	} pins_b_t;

	typedef struct packed {
		pins_a_t a_s1;
		pins_a_t a_s2;
		logic    a_tick_d;
		logic    a_q;
		logic    a_qb;
		pins_b_t b_s1;
		pins_b_t b_s2;
		logic    b_tick_d;
		logic    b_q;
		logic    b_qb;
	} state_t;

endpackage

// ==== rtl/jk_element_pair.sv ====
// Two JK storage elements: one with active-low clear, one with active-high set and clear.
//
// Contract
// R1 - Each element samples J and K and updates only on a rising edge of its timing input.
// R2 - A rising edge toggles on J and K, sets on J, clears on K, else holds; complement mirrors.
// R3 - A low clear forces the clear-only element low, complement high, ignoring clock, J and K.
// R4 - Set alone forces the set-and-clear element high and clear alone low, over any edge.
// R5 - With set and clear both low the set-and-clear element follows the same edge rules.
// R6 - Set and clear both high drive both outputs high; outside logic must not drop both at once.
// R7 - After the controls are released the forced value stays until the next rising edge.
`timescale 1ns/1ps
`include "jk_cell_params.svh"

module jk_element_pair (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic timing_edge_in,
	input  wire logic j_in,
	input  wire logic k_in,
	input  wire logic clear_low_in,
	output logic      q_out,
	output logic      complement_out,
	input  wire logic ps_timing_edge_in,
	input  wire logic ps_j_in,
	input  wire logic ps_k_in,
	input  wire logic ps_set_in,
	input  wire logic ps_clear_in,
	output logic      ps_q_out,
	output logic      ps_complement_out
);

	jk_cell_pkg::state_t  st_r;
	jk_cell_pkg::state_t  st_nxt;
	jk_cell_pkg::pins_a_t pins_a;
	jk_cell_pkg::pins_b_t pins_b;
	logic                 a_rise;
	logic                 b_rise;
	logic                 a_jk;
	logic                 b_jk;

	// Next true output for one rising edge, from the present output and J and K.
	function automatic logic jk_next(input logic q, input logic j, input logic k);
		logic r;
		unique case ({j, k})
			2'b11: r = ~q;
			2'b10: r = 1'b1;
			2'b01: r = 1'b0;
			2'b00: r = q;
		endcase
		return r;
	endfunction

	// Every pin comes from logic outside this clock domain, so each group passes two flops.
	assign pins_a = '{tick: timing_edge_in, j: j_in, k: k_in, clr_n: clear_low_in};
	assign pins_b = '{tick: ps_timing_edge_in, j: ps_j_in, k: ps_k_in,
	                  set: ps_set_in, clr: ps_clear_in};

	// Rising edges are seen only on the second synchroniser stage.
	// A timing pin that holds a level for less than one clock period can lose its edge.
	assign a_rise = st_r.a_s2.tick & ~st_r.a_tick_d; // R1
	assign b_rise = st_r.b_s2.tick & ~st_r.b_tick_d; // R1

	// Next JK value of each element, used only when a rising edge is seen.
	assign a_jk = jk_next(st_r.a_q, st_r.a_s2.j, st_r.a_s2.k); // R2
	assign b_jk = jk_next(st_r.b_q, st_r.b_s2.j, st_r.b_s2.k); // R5

	// The synchroniser stages shift on every clock; the elements then update by priority.
	always_comb begin
		st_nxt          = st_r;
		st_nxt.a_s1     = pins_a;
		st_nxt.a_s2     = st_r.a_s1;
		st_nxt.a_tick_d = st_r.a_s2.tick;
		st_nxt.b_s1     = pins_b;
		st_nxt.b_s2     = st_r.b_s1;
		st_nxt.b_tick_d = st_r.b_s2.tick;

		// Clear is looked at before the edge, so an edge that meets an active clear is lost.
		// Through the synchroniser the clear reaches the outputs on the third clock edge.
		if (!st_r.a_s2.clr_n) begin
			st_nxt.a_q  = 1'b0; // R3
			st_nxt.a_qb = 1'b1; // R3
		end else if (a_rise) begin
			st_nxt.a_q  = a_jk; // R2
			st_nxt.a_qb = ~a_jk; // R2
		end

		// Both controls high drive both outputs high; the next edge restores complement.
		// Dropping both at once leaves both high, which the outside logic must avoid.
		// Set and clear are checked before the edge, so an edge under either is lost.
		if (st_r.b_s2.set && st_r.b_s2.clr) begin
			st_nxt.b_q  = 1'b1; // R6
			st_nxt.b_qb = 1'b1; // R6
		end else if (st_r.b_s2.set) begin
			st_nxt.b_q  = 1'b1; // R4
			st_nxt.b_qb = 1'b0; // R4
		end else if (st_r.b_s2.clr) begin
			st_nxt.b_q  = 1'b0; // R4
			st_nxt.b_qb = 1'b1; // R4
		end else if (b_rise) begin
			st_nxt.b_q  = b_jk; // R5
			st_nxt.b_qb = ~b_jk; // R5
		end
	end

	// Reset loads constants only; the idle levels keep a false edge from following it.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r.a_s1     <= `PINS_A_IDLE;
			st_r.a_s2     <= `PINS_A_IDLE;
			st_r.a_tick_d <= 1'b0;
			st_r.a_q      <= `Q_RESET;
			st_r.a_qb     <= `QB_RESET;
			st_r.b_s1     <= `PINS_B_IDLE;
			st_r.b_s2     <= `PINS_B_IDLE;
			st_r.b_tick_d <= 1'b0;
			st_r.b_q      <= `Q_RESET;
			st_r.b_qb     <= `QB_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign q_out             = st_r.a_q;
	assign complement_out    = st_r.a_qb;
	assign ps_q_out          = st_r.b_q;
	assign ps_complement_out = st_r.b_qb;

	// Checks on the outputs, all on the system clock and quiet during reset.
	chk_no_edge_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
		!a_rise && st_r.a_s2.clr_n |=> $stable(st_r.a_q) && $stable(st_r.a_qb))
		else $error("clear-only element changed without a rising edge");

	chk_jk_toggle_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
		a_rise && st_r.a_s2.clr_n && st_r.a_s2.j && st_r.a_s2.k
		|=> st_r.a_q == !$past(st_r.a_q) && st_r.a_qb == !st_r.a_q)
		else $error("clear-only element did not toggle");

	chk_clear_low_force: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
		$fell(clear_low_in) ##1 !clear_low_in ##1 !clear_low_in
		|=> !q_out && complement_out)
		else $error("low clear did not force outputs within three cycles");

	chk_set_clear_force: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
		st_r.b_s2.set != st_r.b_s2.clr |=> ps_q_out == $past(st_r.b_s2.set)
		&& ps_complement_out == $past(st_r.b_s2.clr))
		else $error("set or clear did not force the outputs");

	chk_jk_ps_cycle: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
		b_rise && !st_r.b_s2.set && !st_r.b_s2.clr && (st_r.b_s2.j != st_r.b_s2.k)
		|=> ps_q_out == $past(st_r.b_s2.j) && ps_complement_out == !ps_q_out)
		else $error("set-and-clear element missed a JK load");

	chk_both_high: assert property (@(posedge ref_clk) disable iff (sys_rst) // R6
		st_r.b_s2.set && st_r.b_s2.clr |=> ps_q_out && ps_complement_out)
		else $error("both controls high did not drive both outputs high");

	chk_release_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
		$fell(st_r.b_s2.clr) && !st_r.b_s2.set && !b_rise
		|=> !ps_q_out && ps_complement_out)
		else $error("forced value lost before the next rising edge");

	// Further checks on both elements.
	chk_clear_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
		!st_r.a_s2.clr_n
		|=> !q_out && complement_out)
		else $error("clear-only element left the cleared state while clear was low");

	chk_jk_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
		a_rise && st_r.a_s2.clr_n && (st_r.a_s2.j != st_r.a_s2.k)
		|=> q_out == $past(st_r.a_s2.j) && complement_out == !q_out)
		else $error("clear-only element missed a JK load");

	chk_jk_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
		a_rise && st_r.a_s2.clr_n && !st_r.a_s2.j && !st_r.a_s2.k
		|=> $stable(q_out) && $stable(complement_out))
		else $error("clear-only element changed on a hold edge");

	chk_mirror_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
		q_out != complement_out)
		else $error("clear-only outputs are not complementary");

	chk_release_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
		$rose(st_r.a_s2.clr_n) && !a_rise
		|=> !q_out && complement_out)
		else $error("clear-only element lost its cleared value before an edge");

	chk_jk_toggle_b: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
		b_rise && !st_r.b_s2.set && !st_r.b_s2.clr && st_r.b_s2.j && st_r.b_s2.k
		|=> ps_q_out == !$past(ps_q_out) && ps_complement_out == !ps_q_out)
		else $error("set-and-clear element did not toggle");

	chk_no_edge_hold_b: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
		!b_rise && !st_r.b_s2.set && !st_r.b_s2.clr
		|=> $stable(ps_q_out) && $stable(ps_complement_out))
		else $error("set-and-clear element changed without a rising edge");

	chk_jk_hold_b: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
		b_rise && !st_r.b_s2.set && !st_r.b_s2.clr && !st_r.b_s2.j && !st_r.b_s2.k
		|=> $stable(ps_q_out) && ps_complement_out == !ps_q_out)
		else $error("set-and-clear element changed on a hold edge");

	chk_set_release_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // R7
		$fell(st_r.b_s2.set) && !$past(st_r.b_s2.clr) && !st_r.b_s2.clr && !b_rise
		|=> ps_q_out && !ps_complement_out)
		else $error("set value lost before the next rising edge");

	chk_clear_beats_edge: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
		b_rise && st_r.b_s2.clr && !st_r.b_s2.set
		|=> !ps_q_out && ps_complement_out)
		else $error("an edge overrode the clear of the set-and-clear element");

	chk_never_both_low: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
		ps_q_out || ps_complement_out)
		else $error("set-and-clear element drove both outputs low");

endmodule

// ==== verification/jk_stim_source.sv ====
// Model of the logic that drives the pins of both storage elements.
`timescale 1ns/1ps
module jk_stim_source (
	input  wire logic            ref_clk,
	output jk_cell_pkg::pins_a_t pins_a,
	output jk_cell_pkg::pins_b_t pins_b
);
	// Pins change a fixed delay after the rising edge and then hold for one cycle.
	task automatic put(input logic t, input logic j, input logic k, input logic s,
			input logic c);
		@(posedge ref_clk);
		#1;
		pins_a = '{tick: t, j: j, k: k, clr_n: ~c};
		pins_b = '{tick: t, j: j, k: k, set: s, clr: c};
	endtask
	initial begin
		pins_a = '{tick: 1'b0, j: 1'b0, k: 1'b0, clr_n: 1'b1};
		pins_b = '0;
	end
endmodule

// ==== verification/test_jk_element_pair.sv ====
// Self-checking testbench for the pair of JK storage elements.
`timescale 1ns/1ps
module test_jk_element_pair;
	logic                 ref_clk;
	logic                 sys_rst;
	jk_cell_pkg::pins_a_t pins_a;
	jk_cell_pkg::pins_b_t pins_b;
	logic [3:0]           outs;
	int                   miscompares;
	int                   tests_run;
	int                   cycles;
	localparam int        cycle_limit = 1000;

	jk_stim_source u_jk_stim_source (.ref_clk(ref_clk), .pins_a(pins_a), .pins_b(pins_b));
	jk_element_pair u_jk_element_pair (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.timing_edge_in(pins_a.tick), .j_in(pins_a.j), .k_in(pins_a.k),
		.clear_low_in(pins_a.clr_n), .q_out(outs[3]), .complement_out(outs[2]),
		.ps_timing_edge_in(pins_b.tick), .ps_j_in(pins_b.j), .ps_k_in(pins_b.k),
		.ps_set_in(pins_b.set), .ps_clear_in(pins_b.clr), .ps_q_out(outs[1]),
		.ps_complement_out(outs[0]));

	task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// Timing pin low, high and low for two cycles each, then both elements are compared.
	task automatic pulse(input logic j, input logic k, input logic s, input logic c,
			input logic [1:0] ea, input logic [1:0] eb);
		for (int i = 0; i < 6; i++)
			u_jk_stim_source.put(i == 2 || i == 3, j, k, s, c);
		check("clear_only", outs[3:2], ea);
		check("set_and_clear", outs[1:0], eb);
	endtask
	task automatic test_jk_table;
		pulse(1, 0, 0, 0, 2'b10, 2'b10);
		pulse(0, 0, 0, 0, 2'b10, 2'b10);
		pulse(1, 1, 0, 0, 2'b01, 2'b01);
		pulse(1, 1, 0, 0, 2'b10, 2'b10);
		pulse(0, 1, 0, 0, 2'b01, 2'b01);
		$display("test_jk_table done");
	endtask
	task automatic test_forcing;
		pulse(0, 1, 1, 0, 2'b01, 2'b10);
		pulse(1, 0, 0, 1, 2'b01, 2'b01);
		pulse(0, 0, 0, 0, 2'b01, 2'b01);
		pulse(1, 0, 0, 0, 2'b10, 2'b10);
		$display("test_forcing done");
	endtask
	task automatic test_both_forced;
		pulse(1, 1, 1, 1, 2'b01, 2'b11);
		pulse(1, 1, 0, 1, 2'b01, 2'b01);
		pulse(0, 0, 0, 0, 2'b01, 2'b01);
		$display("test_both_forced done");
	endtask
	// Controls are released with J and K high and no edge; the forced values must stay.
	task automatic test_release_hold;
		pulse(1, 0, 0, 0, 2'b10, 2'b10);
		repeat (4) u_jk_stim_source.put(0, 1, 1, 0, 1);
		repeat (4) u_jk_stim_source.put(0, 1, 1, 0, 0);
		check("clear_only_released", outs[3:2], 2'b01);
		check("set_and_clear_released", outs[1:0], 2'b01);
		repeat (4) u_jk_stim_source.put(0, 1, 1, 1, 0);
		check("clear_only_no_edge", outs[3:2], 2'b01);
		check("set_and_clear_set", outs[1:0], 2'b10);
		repeat (4) u_jk_stim_source.put(0, 1, 1, 0, 0);
		check("set_and_clear_set_kept", outs[1:0], 2'b10);
		pulse(1, 1, 0, 0, 2'b10, 2'b01);
		$display("test_release_hold done");
	endtask
	// A reset in mid-run returns both elements to their reset levels.
	task automatic test_mid_reset;
		pulse(1, 0, 0, 0, 2'b10, 2'b10);
		@(posedge ref_clk);
		#1 sys_rst = 1'b1;
		@(posedge ref_clk);
		#1;
		check("mid_reset_clear_only", outs[3:2], 2'b01);
		check("mid_reset_set_and_clear", outs[1:0], 2'b01);
		sys_rst = 1'b0;
		pulse(1, 1, 0, 0, 2'b10, 2'b10);
		$display("test_mid_reset done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// A hung run is cut short by the watchdog branch and counted as a mismatch.
	initial begin
		cycles = 0;
		miscompares = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		fork
			begin
				check("reset", outs[3:2], 2'b01);
				check("reset", outs[1:0], 2'b01);
				test_jk_table();
				test_release_hold();
				test_forcing();
				test_both_forced();
				test_mid_reset();
			end
			begin
				while (cycles < cycle_limit) begin
					@(posedge ref_clk);
					cycles++;
				end
				miscompares++;
				$display("timeout after %0d cycles", cycles);
			end
		join_any
		disable fork;
		results();
	end
endmodule
